// ### core/chasi_top.sv
/*
  Fourteen-channel alarm status, change latch and interrupt block with
  a simple synchronous microprocessor register port.
  Assumes detector inputs and bus strobes are synchronous to clk; the
  per-channel enable registers live in this block, the global enable
  and the global mode bits arrive as plain inputs.
*/
`timescale 1ns/100ps
`include "chasi_params.svh"

module chasi_top #(
  parameter int NUM_CH    = `CHASI_NUM_CHANNELS,
  parameter int PTR_WIDTH = 6
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Register port
  input  wire logic [`CHASI_ADDR_WIDTH-1:0]  addr,
  input  wire logic                          read_strobe,
  input  wire logic                          write_strobe,
  input  wire logic [7:0]                    write_data,
  output logic      [7:0]                    read_data,
  output logic                               read_valid,
  // Global controls
  input  wire logic                          global_interrupt_enable,
  input  wire logic                          overflow_mode,
  // Per-channel detector conditions
  input  wire logic [NUM_CH-1:0]             eq_flag_in,
  input  wire logic [NUM_CH-1:0]             driver_fail_in,
  input  wire logic [NUM_CH*PTR_WIDTH-1:0]   rx_fifo_wr_ptr,
  input  wire logic [NUM_CH*PTR_WIDTH-1:0]   rx_fifo_rd_ptr,
  input  wire logic [NUM_CH*PTR_WIDTH-1:0]   tx_fifo_wr_ptr,
  input  wire logic [NUM_CH*PTR_WIDTH-1:0]   tx_fifo_rd_ptr,
  input  wire logic [NUM_CH-1:0]             line_violation_in,
  input  wire logic [NUM_CH-1:0]             counter_overflow_in,
  input  wire logic [NUM_CH-1:0]             loop_code_in,
  input  wire logic [NUM_CH-1:0]             all_ones_in,
  input  wire logic [NUM_CH-1:0]             signal_loss_in,
  input  wire logic [NUM_CH-1:0]             pattern_in,
  input  wire logic [NUM_CH*6-1:0]           cable_attenuation_in,
  // Interrupt
  output logic                               irq_n
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  chasi_pkg::chasi_sel_type  sel;
  logic [3:0]                chan_idx;
  logic [NUM_CH-1:0]         enable_wr;
  logic [NUM_CH-1:0]         change_rd;
  logic [NUM_CH-1:0]         chan_pending;
  chasi_pkg::chasi_byte_type irq_enable    [NUM_CH];
  chasi_pkg::chasi_byte_type next_irq_enable [NUM_CH];
  chasi_pkg::chasi_byte_type live_status   [NUM_CH];
  chasi_pkg::chasi_byte_type change_latch  [NUM_CH];
  chasi_pkg::chasi_byte_type source_cable  [NUM_CH];
  logic [7:0]                next_read_data;
  logic                      next_read_valid;
  logic                      next_irq_n;

  // Channel in the high nibble, register in the low one
  always_comb begin
    chan_idx = addr[7:4];                                         // see RULE18
    sel      = chasi_pkg::CHASI_SEL_NONE;
    if (int'(chan_idx) < NUM_CH) begin
      case (addr[3:0])
        `CHASI_OFS_ENABLE: sel = chasi_pkg::CHASI_SEL_ENABLE;
        `CHASI_OFS_LIVE:   sel = chasi_pkg::CHASI_SEL_LIVE;
        `CHASI_OFS_CHANGE: sel = chasi_pkg::CHASI_SEL_CHANGE;
        `CHASI_OFS_SOURCE: sel = chasi_pkg::CHASI_SEL_SOURCE;
        default:           sel = chasi_pkg::CHASI_SEL_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      // Strobes qualified per channel
      assign enable_wr[ch] = write_strobe && (int'(chan_idx) == ch) &&
                             (sel == chasi_pkg::CHASI_SEL_ENABLE);
      assign change_rd[ch] = read_strobe && (int'(chan_idx) == ch) &&
                             (sel == chasi_pkg::CHASI_SEL_CHANGE); // see RULE11
      // Any latched change gated by its own enable bit
      assign chan_pending[ch] = |(change_latch[ch] & irq_enable[ch]); // see RULE10

      chasi_channel #(
        .PTR_WIDTH (PTR_WIDTH)
      ) u_channel (
        .clk                  (clk),
        .rst_n                (rst_n),
        .eq_flag_in           (eq_flag_in[ch]),
        .driver_fail_in       (driver_fail_in[ch]),
        .rx_fifo_wr_ptr       (rx_fifo_wr_ptr[ch*PTR_WIDTH +: PTR_WIDTH]),
        .rx_fifo_rd_ptr       (rx_fifo_rd_ptr[ch*PTR_WIDTH +: PTR_WIDTH]),
        .tx_fifo_wr_ptr       (tx_fifo_wr_ptr[ch*PTR_WIDTH +: PTR_WIDTH]),
        .tx_fifo_rd_ptr       (tx_fifo_rd_ptr[ch*PTR_WIDTH +: PTR_WIDTH]),
        .line_violation_in    (line_violation_in[ch]),
        .counter_overflow_in  (counter_overflow_in[ch]),
        .loop_code_in         (loop_code_in[ch]),
        .all_ones_in          (all_ones_in[ch]),
        .signal_loss_in       (signal_loss_in[ch]),
        .pattern_in           (pattern_in[ch]),
        .cable_attenuation_in (cable_attenuation_in[ch*6 +: 6]),
        .overflow_mode        (overflow_mode),                    // see RULE2
        .change_read          (change_rd[ch]),
        .live_status          (live_status[ch]),
        .change_latch         (change_latch[ch]),
        .source_and_cable     (source_cable[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Enable registers, read mux and interrupt
  // ----------------------------------------------------------------
  // Enable register: plain read/write, clear after reset
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_irq_enable[i] = enable_wr[i] ? write_data : irq_enable[i];
    end
  end

  // Read returns the value before the clear takes effect
  always_comb begin
    next_read_valid = read_strobe;
    next_read_data  = 8'h00;                                      // Unmapped reads zero
    if (read_strobe) begin
      case (sel)
        chasi_pkg::CHASI_SEL_ENABLE: next_read_data = irq_enable[chan_idx];
        chasi_pkg::CHASI_SEL_LIVE:   next_read_data = live_status[chan_idx];
        chasi_pkg::CHASI_SEL_CHANGE: next_read_data = change_latch[chan_idx]; // see RULE11
        chasi_pkg::CHASI_SEL_SOURCE: next_read_data = source_cable[chan_idx];
        default:                     next_read_data = 8'h00;
      endcase
    end
    // Pin stays quiet until software sets the global enable too
    next_irq_n = !(global_interrupt_enable && (|chan_pending));   // see RULE10, RULE17
  end

  // Registered outputs; interrupt deasserted during reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        irq_enable[i] <= `CHASI_REG_RESET;
      end
      read_data  <= `CHASI_REG_RESET;
      read_valid <= 1'b0;
      irq_n      <= 1'b1;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        irq_enable[i] <= next_irq_enable[i];
      end
      read_data  <= next_read_data;
      read_valid <= next_read_valid;
      irq_n      <= next_irq_n;
    end
  end

endmodule : chasi_top

// ### common/chasi_params.svh
/*
  Offsets, field positions, reset values and sizes for the per-channel
  alarm status and interrupt block.
  Assumes it is included by bare name from the package and the design files.
*/
`ifndef CHASI_PARAMS_SVH
`define CHASI_PARAMS_SVH

// Summary of operation
// RULE1: Violation bit shows line code violations by default
// RULE2: Global mode bit selects counter overflow instead
// RULE3: Violation bit set on LCV, BPV or excess zeros
// RULE4: Loop-code bit follows detector, per-channel mode
// RULE5: All-ones alarm bit follows all-ones detection
// RULE6: Signal-loss bit follows loss-of-signal condition
// RULE7: Pattern bit follows quasi-random pattern detection
// RULE8: Live bits track regardless of interrupt masking
// RULE9: Any status change sets latched change bit
// RULE10: Interrupt needs channel enable and global enable
// RULE11: Reading change register returns then clears it
// RULE12: FIFO source bit: 0 receive, 1 transmit
// RULE13: Both FIFOs at limit reads source one
// RULE14: Six-bit cable attenuation estimate in bits 5:0
// RULE15: FIFO limit bit set when pointers within three
// RULE16: Driver monitor bit set on driver failure
// RULE17: Software sets global and channel enables first
// RULE18: Fourteen channels, stride 0x10 between copies
// RULE19: Change in read cycle survives the clear
// RULE20: All bits zero after reset, bit 7 zero

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CHASI_NUM_CHANNELS   14
`define CHASI_ADDR_WIDTH     8
`define CHASI_CHAN_STRIDE    8'h10
`define CHASI_OFS_ENABLE     4'h4
`define CHASI_OFS_LIVE       4'h5
`define CHASI_OFS_CHANGE     4'h6
`define CHASI_OFS_SOURCE     4'h7
`define CHASI_REG_RESET      8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CHASI_BIT_EQ         7
`define CHASI_BIT_DRV        6
`define CHASI_BIT_FIFO       5
`define CHASI_BIT_LCV        4
`define CHASI_BIT_LOOP       3
`define CHASI_BIT_AIS        2
`define CHASI_BIT_LOS        1
`define CHASI_BIT_PAT        0
`define CHASI_BIT_SRC        6
`define CHASI_CABLE_WIDTH    6
`define CHASI_FIFO_NEAR      3

`endif

// ### common/chasi_pkg.sv
/*
  Types shared by the alarm status block.
  Assumes chasi_params.svh is on the include path.
*/
`include "chasi_params.svh"

package chasi_pkg;

  // ----------------------------------------------------------------
  // Register selector decoded from the channel offset
  // ----------------------------------------------------------------
  typedef enum {
    CHASI_SEL_NONE,
    CHASI_SEL_ENABLE,
    CHASI_SEL_LIVE,
    CHASI_SEL_CHANGE,
    CHASI_SEL_SOURCE
  } chasi_sel_type;

  typedef logic [7:0] chasi_byte_type;

endpackage : chasi_pkg

// ### core/chasi_channel.sv
/*
  One channel's live status, change latch and FIFO source / cable bits.
  Assumes detector inputs are synchronous to clk and registered upstream.
*/
`timescale 1ns/100ps
`include "chasi_params.svh"

module chasi_channel #(
  parameter int PTR_WIDTH = 6
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Detector conditions
  input  wire logic                  eq_flag_in,
  input  wire logic                  driver_fail_in,
  input  wire logic [PTR_WIDTH-1:0]  rx_fifo_wr_ptr,
  input  wire logic [PTR_WIDTH-1:0]  rx_fifo_rd_ptr,
  input  wire logic [PTR_WIDTH-1:0]  tx_fifo_wr_ptr,
  input  wire logic [PTR_WIDTH-1:0]  tx_fifo_rd_ptr,
  input  wire logic                  line_violation_in,
  input  wire logic                  counter_overflow_in,
  input  wire logic                  loop_code_in,
  input  wire logic                  all_ones_in,
  input  wire logic                  signal_loss_in,
  input  wire logic                  pattern_in,
  input  wire logic [5:0]            cable_attenuation_in,
  input  wire logic                  overflow_mode,
  // Register access
  input  wire logic                  change_read,
  output chasi_pkg::chasi_byte_type  live_status,
  output chasi_pkg::chasi_byte_type  change_latch,
  output chasi_pkg::chasi_byte_type  source_and_cable
);

  chasi_pkg::chasi_byte_type next_live_status;
  chasi_pkg::chasi_byte_type next_change_latch;
  chasi_pkg::chasi_byte_type next_source_and_cable;
  logic [PTR_WIDTH-1:0]      rx_gap;
  logic [PTR_WIDTH-1:0]      tx_gap;
  logic                      rx_near;
  logic                      tx_near;

  // ----------------------------------------------------------------
  // Next-state computation
  // ----------------------------------------------------------------
  // Pointer distance either way round; wrap handled by modulo arithmetic
  always_comb begin
    rx_gap  = rx_fifo_wr_ptr - rx_fifo_rd_ptr;
    tx_gap  = tx_fifo_wr_ptr - tx_fifo_rd_ptr;
    rx_near = (rx_gap <= PTR_WIDTH'(`CHASI_FIFO_NEAR)) ||
              (rx_gap >= PTR_WIDTH'(-`CHASI_FIFO_NEAR));          // see RULE15
    tx_near = (tx_gap <= PTR_WIDTH'(`CHASI_FIFO_NEAR)) ||
              (tx_gap >= PTR_WIDTH'(-`CHASI_FIFO_NEAR));          // see RULE15
    // Live bits ignore enables entirely
    next_live_status                  = 8'h00;                    // see RULE8
    next_live_status[`CHASI_BIT_EQ]   = eq_flag_in;
    next_live_status[`CHASI_BIT_DRV]  = driver_fail_in;           // see RULE16
    next_live_status[`CHASI_BIT_FIFO] = rx_near | tx_near;        // see RULE15
    next_live_status[`CHASI_BIT_LCV]  = overflow_mode ? counter_overflow_in // see RULE2
                                                      : line_violation_in;  // see RULE1, RULE3
    next_live_status[`CHASI_BIT_LOOP] = loop_code_in;             // see RULE4
    next_live_status[`CHASI_BIT_AIS]  = all_ones_in;              // see RULE5
    next_live_status[`CHASI_BIT_LOS]  = signal_loss_in;           // see RULE6
    next_live_status[`CHASI_BIT_PAT]  = pattern_in;               // see RULE7
    // Set wins over the read clear so no edge is lost
    next_change_latch = (change_read ? 8'h00 : change_latch)      // see RULE11
                      | (next_live_status ^ live_status);         // see RULE9, RULE19
    // Bit 7 stays zero; transmit wins when both FIFOs are at limit
    next_source_and_cable = {1'b0,
                             tx_near,                             // see RULE12, RULE13
                             cable_attenuation_in};               // see RULE14, RULE20
  end

  // Registers only; all start clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_status      <= `CHASI_REG_RESET;                       // see RULE20
      change_latch     <= `CHASI_REG_RESET;
      source_and_cable <= `CHASI_REG_RESET;
    end else begin
      live_status      <= next_live_status;
      change_latch     <= next_change_latch;
      source_and_cable <= next_source_and_cable;
    end
  end

endmodule : chasi_channel

// ### tb/chasi_checker.sv
/*
  Concurrent checks on the register port, live status reads and
  interrupt gating of chasi_top, bound to every instance of it.
  Assumes the channel 0 status offset is 0x05 and a single clock domain.
*/
`timescale 1ns/100ps

module chasi_checker #(
  parameter int NUM_CH    = 14,
  parameter int PTR_WIDTH = 6
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [7:0]        addr,
  input wire logic              read_strobe,
  input wire logic [7:0]        read_data,
  input wire logic              read_valid,
  // Controls and conditions
  input wire logic              global_interrupt_enable,
  input wire logic              overflow_mode,
  input wire logic [NUM_CH-1:0] line_violation_in,
  input wire logic [NUM_CH-1:0] counter_overflow_in,
  input wire logic [NUM_CH-1:0] all_ones_in,
  input wire logic [NUM_CH-1:0] signal_loss_in,
  // Interrupt
  input wire logic              irq_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Status checks wait for inputs held over two edges, so either
  // sampling order of the live register satisfies them
  a_read_gets_answer: assert property (read_strobe |=> read_valid)
    else $error("read not answered");
  a_no_stray_valid: assert property (!read_strobe |=>
    !read_valid && read_data == 8'h00)
    else $error("valid or data without read");
  a_unmapped_reads_zero: assert property (read_strobe &&
    (addr[7:4] > 4'hd || addr[3:0] < 4'h4 || addr[3:0] > 4'h7) |=> read_data == 8'h00)
    else $error("unmapped read not zero");
  a_spare_bit_zero: assert property (read_strobe &&
    addr[3:0] == 4'h7 |=> !read_data[7])
    else $error("cable register bit 7 set");
  a_loss_bit_tracks: assert property ($past(rst_n) && read_strobe &&
    addr == 8'h05 && $stable(signal_loss_in[0]) |=> read_data[1] == $past(signal_loss_in[0]))
    else $error("loss bit wrong");
  a_ais_bit_tracks: assert property ($past(rst_n) && read_strobe &&
    addr == 8'h05 && $stable(all_ones_in[0]) |=> read_data[2] == $past(all_ones_in[0]))
    else $error("all ones bit wrong");
  a_violation_mode_select: assert property ($past(rst_n) && read_strobe &&
    addr == 8'h05 && $stable(overflow_mode) && $stable(line_violation_in[0]) &&
    $stable(counter_overflow_in[0]) |=> read_data[4] == ($past(overflow_mode) ?
    $past(counter_overflow_in[0]) : $past(line_violation_in[0])))
    else $error("violation bit wrong source");
  a_irq_needs_global: assert property (!global_interrupt_enable |=> irq_n)
    else $error("interrupt without global enable");

  // Main scenarios reached
  c_change_read: cover property (read_strobe && addr[3:0] == 4'h6);
  c_irq_asserted: cover property ($fell(irq_n));
  c_overflow_read: cover property (overflow_mode && read_strobe && addr == 8'h05);
endmodule : chasi_checker

bind chasi_top chasi_checker #(.NUM_CH(NUM_CH), .PTR_WIDTH(PTR_WIDTH)) chasi_checker_i (
  .clk, .rst_n, .addr, .read_strobe, .read_data, .read_valid, .global_interrupt_enable,
  .overflow_mode, .line_violation_in, .counter_overflow_in, .all_ones_in, .signal_loss_in,
  .irq_n
);

// ### tb/chasi_tb_top.sv
/*
  Self-checking bench for chasi_top: reset values, live status, change
  latch, interrupt gating, FIFO source and cable bits.
  Assumes chasi_checker is bound by its own file; inputs move at negedge.
*/
`timescale 1ns/100ps

module chasi_tb_top;
  localparam int NC = 14;
  localparam int PW = 6;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             clk, rst_n, read_strobe, write_strobe, read_valid, irq_n;
  logic             global_interrupt_enable, overflow_mode;
  logic [7:0]       addr, write_data, read_data;
  logic [NC-1:0]    eq_flag_in, driver_fail_in, line_violation_in, counter_overflow_in;
  logic [NC-1:0]    loop_code_in, all_ones_in, signal_loss_in, pattern_in;
  logic [NC*PW-1:0] rx_fifo_wr_ptr, rx_fifo_rd_ptr, tx_fifo_wr_ptr, tx_fifo_rd_ptr;
  logic [NC*6-1:0]  cable_attenuation_in;
  int               err_total = 0;
  int               checked = 0;
  int               cyc = 0;

  chasi_top #(.NUM_CH(NC), .PTR_WIDTH(PW)) chasi_top_i (
    .clk, .rst_n, .addr, .read_strobe, .write_strobe, .write_data, .read_data,
    .read_valid, .global_interrupt_enable, .overflow_mode, .eq_flag_in,
    .driver_fail_in, .rx_fifo_wr_ptr, .rx_fifo_rd_ptr, .tx_fifo_wr_ptr,
    .tx_fifo_rd_ptr, .line_violation_in, .counter_overflow_in, .loop_code_in,
    .all_ones_in, .signal_loss_in, .pattern_in, .cable_attenuation_in, .irq_n
  );

  // Clock and hang guard; the whole run needs well under 2000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks, all entered at a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Trailing idle cycle keeps the strobe from being set twice in a step
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    read_strobe = 1'b1;
    @(negedge clk);
    read_strobe = 1'b0;
    chk("read_valid", 8'h01, {7'h00, read_valid});
    chk($sformatf("reg %h", a), exp, read_data);
    @(negedge clk);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    write_data = d;
    write_strobe = 1'b1;
    @(negedge clk);
    write_strobe = 1'b0;
    @(negedge clk);
  endtask : wr

  // Bit 5 goes through the receive pointers: offset 3 near, 4 far
  task automatic set_ch(input int ch, input logic [7:0] v);
    eq_flag_in[ch] = v[7];
    driver_fail_in[ch] = v[6];
    rx_fifo_wr_ptr[ch*PW +: PW] = v[5] ? 6'h23 : 6'h24;
    line_violation_in[ch] = v[4];
    loop_code_in[ch] = v[3];
    all_ones_in[ch] = v[2];
    signal_loss_in[ch] = v[1];
    pattern_in[ch] = v[0];
  endtask : set_ch

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int c = 0; c < NC; c++) begin
      for (int r = 5; r < 8; r++) begin
        rd(8'(c * 16 + r), 8'h00);
      end
    end
    rd(8'he5, 8'h00);
    rd(8'h03, 8'h00);
  endtask : t_reset

  // Walk one condition at a time with every interrupt masked
  task automatic t_live();
    for (int b = 0; b < 8; b++) begin
      set_ch(0, 8'h01 << b);
      @(negedge clk);
      rd(8'h05, 8'h01 << b);
      rd(8'h06, 8'((9'h003 << b) >> 1));
      rd(8'h06, 8'h00);
      chk("irq_n", 8'h01, {7'h00, irq_n});
    end
    set_ch(0, 8'h10);
    @(negedge clk);
    rd(8'h05, 8'h10);
    overflow_mode = 1'b1;
    @(negedge clk);
    rd(8'h05, 8'h00);
    counter_overflow_in[0] = 1'b1;
    @(negedge clk);
    rd(8'h05, 8'h10);
  endtask : t_live

  task automatic t_fifo();
    cable_attenuation_in[5*6 +: 6] = 6'h2d;
    set_ch(5, 8'h20);
    @(negedge clk);
    rd(8'h55, 8'h20);
    rd(8'h57, 8'h2d);
    tx_fifo_wr_ptr[5*PW +: PW] = 6'h1d;
    @(negedge clk);
    rd(8'h57, 8'h6d);
    set_ch(5, 8'h00);
    @(negedge clk);
    rd(8'h57, 8'h6d);
    tx_fifo_wr_ptr[5*PW +: PW] = 6'h1c;
    @(negedge clk);
    rd(8'h55, 8'h00);
  endtask : t_fifo

  // Writes off the enable offset are ignored; enable reads back as written
  task automatic t_irq();
    wr(8'h15, 8'hff);
    rd(8'h14, 8'h00);
    wr(8'h14, 8'h01);
    rd(8'h14, 8'h01);
    set_ch(1, 8'h02);
    repeat (3) @(negedge clk);
    chk("irq_n masked", 8'h01, {7'h00, irq_n});
    rd(8'h16, 8'h02);
    set_ch(1, 8'h03);
    repeat (3) @(negedge clk);
    chk("irq_n no global", 8'h01, {7'h00, irq_n});
    global_interrupt_enable = 1'b1;
    @(negedge clk);
    chk("irq_n enabled", 8'h00, {7'h00, irq_n});
    rd(8'h16, 8'h01);
    chk("irq_n cleared", 8'h01, {7'h00, irq_n});
  endtask : t_irq

  // Change landing on the read edge must survive the clear
  task automatic t_race();
    set_ch(2, 8'h04);
    rd(8'h26, 8'h00);
    rd(8'h26, 8'h04);
  endtask : t_race

  task automatic results();
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // Main sequence; pointer defaults keep every FIFO far from its limit
  initial begin
    rst_n = 1'b0;
    {read_strobe, write_strobe, global_interrupt_enable, overflow_mode} = 4'h0;
    {addr, write_data} = 16'h0000;
    {eq_flag_in, driver_fail_in, line_violation_in, counter_overflow_in} = '0;
    {loop_code_in, all_ones_in, signal_loss_in, pattern_in} = '0;
    cable_attenuation_in = '0;
    rx_fifo_rd_ptr = {NC{6'h20}};
    rx_fifo_wr_ptr = {NC{6'h24}};
    tx_fifo_rd_ptr = {NC{6'h20}};
    tx_fifo_wr_ptr = {NC{6'h10}};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_live();
    t_fifo();
    t_irq();
    t_race();
    results();
  end
endmodule : chasi_tb_top
